// file: design/pat_pkg.sv
// Package for the paged address translator: constants, types, helpers
package pat_pkg;
  // Shadow window bases
  localparam logic [15:0] SHADOW_BASE_NORMAL = 16'hFF00;
  localparam logic [15:0] SHADOW_BASE_EXT = 16'hFE00;
  // Virtual address fields
  localparam int VPN_LO = 10;
  localparam int VPN_W = 6;
  localparam int OFFSET_W = 10;
  // Page table entry fields
  localparam int FLD_WRITE_PERMIT = 15;
  localparam int FLD_READ_PERMIT = 14;
  localparam int FLD_FETCH_PERMIT = 13;
  localparam int FLD_WRITTEN = 12;
  localparam int FLD_USED = 11;
  localparam int FLD_RING_LO = 9;
  localparam int FLD_PROT_LO = 9;
  localparam int PPN_NORMAL_W = 9;
  localparam int PPN_EXT_W = 14;
  localparam int FLD_EXT_PPN_LO = 16;
  localparam logic [31:0] MASK_NORMAL_WORD = 32'h0000_FFFF;
  localparam logic [31:0] MASK_EXT_PROT = 32'h0000_FE00;
  localparam logic [31:0] MASK_EXT_PPN = 32'h3FFF_0000;
  localparam logic [31:0] ENTRY_RESET = 32'h0000_0000;
  // Level paging control fields
  localparam int PCR_PT_LO = 9;
  localparam int PCR_APT_LO = 7;
  localparam int PCR_LVL_LO = 3;
  localparam int PCR_RING_LO = 0;
  localparam logic [1:0] RING_TOP = 2'h3;
  // Internal interrupt
  localparam logic [3:0] IRQ_LEVEL = 4'hE;
  localparam logic [3:0] CODE_PROT_VIOL = 4'h2;
  localparam logic [3:0] CODE_PAGE_FAULT = 4'h3;

  typedef enum logic [1:0] {
    ACC_FETCH,
    ACC_READ,
    ACC_WRITE,
    ACC_INDIRECT
  } pat_acc_t;

  typedef struct packed {
    logic [1:0] table_sel;
    logic [1:0] alt_table_sel;
    logic [1:0] ring;
  } pat_pcr_t;

  typedef struct packed {
    logic valid;
    logic [15:0] vaddr;
    pat_acc_t acc;
    logic pc_rel;
    logic [15:0] wdata;
  } pat_req_t;

  typedef struct packed {
    logic bus_valid;
    logic [23:0] paddr;
    logic shadow_valid;
    logic [15:0] shadow_rdata;
    logic irq;
    logic [3:0] irq_level;
    logic [3:0] irq_code;
  } pat_resp_t;

  // Flat entry index from table and page
  function automatic logic [7:0] tbl_index(input logic [1:0] tbl, input logic [5:0] page);
    tbl_index = {tbl, page};
  endfunction : tbl_index
endpackage : pat_pkg

// file: design/pat_table_store.sv
// Four page tables of 64 entries, 32 bits each, with masked write
`timescale 1ns/1ps
module pat_table_store import pat_pkg::*; (
  // Clock and reset
  input wire logic clock_i,
  input wire logic rst_i,
  // Masked write port
  input wire logic wr_en_i,
  input wire logic [7:0] wr_idx_i,
  input wire logic [31:0] wr_data_i,
  input wire logic [31:0] wr_mask_i,
  // Read ports
  input wire logic [7:0] rd_a_idx_i,
  output logic [31:0] rd_a_data_o,
  input wire logic [7:0] rd_b_idx_i,
  output logic [31:0] rd_b_data_o
);
  logic [31:0] mem_q [256];
  logic [31:0] mem_d [256];

  always_comb begin
    mem_d = mem_q;
    if (wr_en_i) begin
      mem_d[wr_idx_i] = (mem_q[wr_idx_i] & ~wr_mask_i) | (wr_data_i & wr_mask_i);
    end
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      for (int i = 0; i < 256; i++) begin
        mem_q[i] <= ENTRY_RESET;
      end
    end else begin
      mem_q <= mem_d;
    end
  end

  assign rd_a_data_o = mem_q[rd_a_idx_i];
  assign rd_b_data_o = mem_q[rd_b_idx_i];
endmodule : pat_table_store

// file: design/pat_level_ctrl.sv
// Sixteen per-level paging control registers
`timescale 1ns/1ps
module pat_level_ctrl import pat_pkg::*; (
  // Clock and reset
  input wire logic clock_i,
  input wire logic rst_i,
  // Load from accumulator format
  input wire logic wr_i,
  input wire logic [15:0] wdata_i,
  // Current level lookup
  input wire logic [3:0] cur_level_i,
  output pat_pcr_t cur_pcr_o,
  // Maintenance read-back
  input wire logic [3:0] rd_level_i,
  output logic [15:0] rd_word_o
);
  pat_pcr_t pcr_q [16];
  pat_pcr_t pcr_d [16];
  pat_pcr_t rd_sel;
  logic [3:0] wr_level;

  always_comb begin
    pcr_d = pcr_q;
    wr_level = wdata_i[PCR_LVL_LO +: 4];
    if (wr_i) begin
      pcr_d[wr_level].table_sel = wdata_i[PCR_PT_LO +: 2];
      pcr_d[wr_level].alt_table_sel = wdata_i[PCR_APT_LO +: 2];
      pcr_d[wr_level].ring = wdata_i[PCR_RING_LO +: 2];
    end
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      for (int i = 0; i < 16; i++) begin
        pcr_q[i] <= '0;
      end
    end else begin
      pcr_q <= pcr_d;
    end
  end

  assign cur_pcr_o = pcr_q[cur_level_i];
  assign rd_sel = pcr_q[rd_level_i];
  assign rd_word_o = {5'h0_0, rd_sel.table_sel, rd_sel.alt_table_sel, rd_level_i, 1'b0, rd_sel.ring};
endmodule : pat_level_ctrl

// file: design/pat_translator.sv
// Paged address translator: lookup, shadow window, flags and protection trap
// Notes on behaviour
// - Map 16-bit virtual address to 19-bit normal or 24-bit extended physical.
// - 1024-word pages; low ten address bits pass through untranslated.
// - Address bits 10 to 15 index one of 64 entries.
// - Four tables of 64 entries, 32 bits wide, each covering all space.
// - Program level picks control register; it picks the page table.
// - Entry gives 9 or 14 page bits plus 7 protection bits.
// - Top 256 or 512 virtual addresses form the page table window.
// - Rings 0-2 see memory there; ring 3 or paging off see tables.
// - Normal mode: one window word reads or writes a whole 16-bit entry.
// - Extended mode: entry is two window words, protection then page number.
// - Normal entry: permits 13-15, written 12, used 11, ring 9-10, page 0-8.
// - Extended page-number word holds 14-bit page number in bits 0-13.
// - First write sets the written flag; it stays until software clears.
// - Any permitted translated access sets the used flag; it stays until software clears.
// - Non PC-relative references use the alternate table when enabled.
// - Indirect pointer fetch PC-relative uses primary; operand uses alternate.
// - Protection violation raises level 14 interrupt with code 2.
// - All permits zero means page absent: page fault interrupt.
// - Control register holds primary table, alternate table and ring fields.
`timescale 1ns/1ps
module pat_translator import pat_pkg::*; (
  // Clock and reset
  input wire logic clock_i,
  input wire logic rst_i,
  // Processor state
  input wire logic [3:0] program_level_i,
  input wire logic extended_mode_i,
  input wire logic paging_on_i,
  input wire logic alternate_table_enable_i,
  // Memory reference from the core
  input wire pat_req_t req_i,
  // Answer to the core
  output pat_resp_t resp_o,
  // Level paging control load and read-back
  input wire logic pcr_wr_i,
  input wire logic [15:0] pcr_wdata_i,
  input wire logic [3:0] pcr_rd_level_i,
  output logic [15:0] pcr_rdata_o
);
  pat_pcr_t ctrl;
  logic [15:0] pcr_word;
  logic [5:0] virtual_page_number;
  logic [9:0] in_page_offset;
  logic [1:0] tbl_sel;
  logic [7:0] xlate_idx;
  logic [7:0] shadow_idx;
  logic [31:0] xlate_entry;
  logic [31:0] shadow_entry;
  logic in_window;
  logic shadow_hit;
  logic translate;
  logic use_alt;
  logic write_permit;
  logic read_permit;
  logic fetch_permit;
  logic [1:0] page_ring;
  logic not_present;
  logic permit_ok;
  logic ring_ok;
  logic protection_violation;
  logic xlate_ok;
  logic [23:0] xlate_addr;
  logic [15:0] shadow_word;
  logic wr_en;
  logic [7:0] wr_idx;
  logic [31:0] wr_data;
  logic [31:0] wr_mask;
  pat_resp_t resp_d;
  pat_resp_t resp_q;
  logic [15:0] pcr_rdata_d;
  logic [15:0] pcr_rdata_q;

  pat_level_ctrl u_level_ctrl (
    .clock_i(clock_i),
    .rst_i(rst_i),
    .wr_i(pcr_wr_i),
    .wdata_i(pcr_wdata_i),
    .cur_level_i(program_level_i),
    .cur_pcr_o(ctrl),
    .rd_level_i(pcr_rd_level_i),
    .rd_word_o(pcr_word)
  );

  pat_table_store u_table_store (
    .clock_i(clock_i),
    .rst_i(rst_i),
    .wr_en_i(wr_en),
    .wr_idx_i(wr_idx),
    .wr_data_i(wr_data),
    .wr_mask_i(wr_mask),
    .rd_a_idx_i(xlate_idx),
    .rd_a_data_o(xlate_entry),
    .rd_b_idx_i(shadow_idx),
    .rd_b_data_o(shadow_entry)
  );

  // Address split and table choice
  always_comb begin
    virtual_page_number = req_i.vaddr[VPN_LO +: VPN_W];
    in_page_offset = req_i.vaddr[OFFSET_W-1:0];
    use_alt = alternate_table_enable_i && !req_i.pc_rel;
    tbl_sel = use_alt ? ctrl.alt_table_sel : ctrl.table_sel;
    xlate_idx = tbl_index(tbl_sel, virtual_page_number);
  end

  // Shadow window decode
  always_comb begin
    if (extended_mode_i) begin
      in_window = req_i.vaddr >= SHADOW_BASE_EXT;
      shadow_idx = req_i.vaddr[8:1];
    end else begin
      in_window = req_i.vaddr >= SHADOW_BASE_NORMAL;
      shadow_idx = req_i.vaddr[7:0];
    end
    shadow_hit = in_window && (!paging_on_i || ctrl.ring == RING_TOP);
    translate = paging_on_i && !shadow_hit;
  end

  // Shadow read word
  always_comb begin
    if (!extended_mode_i) begin
      shadow_word = shadow_entry[15:0];
    end else if (!req_i.vaddr[0]) begin
      shadow_word = {shadow_entry[15:FLD_PROT_LO], 9'h000};
    end else begin
      shadow_word = {2'h0, shadow_entry[FLD_EXT_PPN_LO +: PPN_EXT_W]};
    end
  end

  // Permit and ring checks
  always_comb begin
    write_permit = xlate_entry[FLD_WRITE_PERMIT];
    read_permit = xlate_entry[FLD_READ_PERMIT];
    fetch_permit = xlate_entry[FLD_FETCH_PERMIT];
    page_ring = xlate_entry[FLD_RING_LO +: 2];
    not_present = !write_permit && !read_permit && !fetch_permit;
    unique case (req_i.acc)
      ACC_FETCH: permit_ok = fetch_permit;
      ACC_READ: permit_ok = read_permit;
      ACC_WRITE: permit_ok = write_permit;
      ACC_INDIRECT: permit_ok = read_permit || fetch_permit;
    endcase
    ring_ok = ctrl.ring >= page_ring;
    protection_violation = !not_present && (!permit_ok || !ring_ok);
    xlate_ok = req_i.valid && translate && !not_present && !protection_violation;
  end

  // Physical address forming
  always_comb begin
    if (!paging_on_i) begin
      xlate_addr = {8'h00, req_i.vaddr};
    end else if (extended_mode_i) begin
      xlate_addr = {xlate_entry[FLD_EXT_PPN_LO +: PPN_EXT_W], in_page_offset};
    end else begin
      xlate_addr = {5'h00, xlate_entry[PPN_NORMAL_W-1:0], in_page_offset};
    end
  end

  // Table write: shadow store or automatic flags
  always_comb begin
    wr_en = 1'b0;
    wr_idx = xlate_idx;
    wr_data = '0;
    wr_mask = '0;
    if (req_i.valid && shadow_hit && req_i.acc == ACC_WRITE) begin
      wr_en = 1'b1;
      wr_idx = shadow_idx;
      if (!extended_mode_i) begin
        wr_data = {16'h0000, req_i.wdata};
        wr_mask = MASK_NORMAL_WORD;
      end else if (!req_i.vaddr[0]) begin
        wr_data = {16'h0000, req_i.wdata};
        wr_mask = MASK_EXT_PROT;
      end else begin
        wr_data = {2'h0, req_i.wdata[PPN_EXT_W-1:0], 16'h0000};
        wr_mask = MASK_EXT_PPN;
      end
    end else if (xlate_ok) begin
      wr_en = 1'b1;
      wr_data[FLD_USED] = 1'b1;
      wr_mask[FLD_USED] = 1'b1;
      wr_data[FLD_WRITTEN] = req_i.acc == ACC_WRITE;
      wr_mask[FLD_WRITTEN] = req_i.acc == ACC_WRITE;
    end
  end

  // Answer for the reference, one cycle later
  always_comb begin
    resp_d = '0;
    resp_d.paddr = resp_q.paddr;
    resp_d.shadow_rdata = resp_q.shadow_rdata;
    resp_d.irq_level = resp_q.irq_level;
    resp_d.irq_code = resp_q.irq_code;
    if (req_i.valid) begin
      if (shadow_hit) begin
        resp_d.shadow_valid = 1'b1;
        resp_d.shadow_rdata = shadow_word;
      end else if (!paging_on_i || xlate_ok) begin
        resp_d.bus_valid = 1'b1;
        resp_d.paddr = xlate_addr;
      end else begin
        resp_d.irq = 1'b1;
        resp_d.irq_level = IRQ_LEVEL;
        resp_d.irq_code = not_present ? CODE_PAGE_FAULT : CODE_PROT_VIOL;
      end
    end
    pcr_rdata_d = pcr_word;
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      resp_q <= '0;
      pcr_rdata_q <= '0;
    end else begin
      resp_q <= resp_d;
      pcr_rdata_q <= pcr_rdata_d;
    end
  end

  assign resp_o = resp_q;
  assign pcr_rdata_o = pcr_rdata_q;

  // Checks
  AST_OFFSET_PASS: assert property (@(posedge clock_i) disable iff (rst_i)
    resp_o.bus_valid |-> resp_o.paddr[9:0] == $past(req_i.vaddr[9:0]))
    else $error("In-page offset altered");

  AST_NORMAL_WIDTH: assert property (@(posedge clock_i) disable iff (rst_i)
    $past(req_i.valid && paging_on_i && !extended_mode_i) && resp_o.bus_valid |-> resp_o.paddr[23:19] == 5'h00)
    else $error("Normal mode address wider than 19 bits");

  AST_PPN_SOURCE: assert property (@(posedge clock_i) disable iff (rst_i)
    xlate_ok && extended_mode_i |=> resp_o.paddr[23:10] == $past(xlate_entry[29:16]))
    else $error("Extended page number not from entry");

  AST_PPN_NORMAL: assert property (@(posedge clock_i) disable iff (rst_i)
    xlate_ok && !extended_mode_i |=> resp_o.paddr[18:10] == $past(xlate_entry[8:0]))
    else $error("Normal page number not from entry");

  AST_WINDOW_TABLES: assert property (@(posedge clock_i) disable iff (rst_i)
    req_i.valid && in_window && !paging_on_i |=> resp_o.shadow_valid && !resp_o.bus_valid)
    else $error("Window did not reach tables with paging off");

  AST_LOW_RING_MEMORY: assert property (@(posedge clock_i) disable iff (rst_i)
    req_i.valid && in_window && paging_on_i && ctrl.ring != 2'h3 |=> !resp_o.shadow_valid)
    else $error("Low ring reached page tables");

  AST_USED_WRITTEN: assert property (@(posedge clock_i) disable iff (rst_i)
    xlate_ok && req_i.acc == ACC_WRITE |-> wr_en && wr_data[12] && wr_data[11] && wr_idx == xlate_idx)
    else $error("Flags not set on write");

  AST_ALT_TABLE: assert property (@(posedge clock_i) disable iff (rst_i)
    alternate_table_enable_i && !req_i.pc_rel |-> xlate_idx[7:6] == ctrl.alt_table_sel)
    else $error("Alternate table not chosen");

  AST_MPV_CODE: assert property (@(posedge clock_i) disable iff (rst_i)
    req_i.valid && translate && protection_violation |=> resp_o.irq && resp_o.irq_code == 4'h2
      && resp_o.irq_level == 4'hE && !resp_o.bus_valid)
    else $error("Violation not trapped with code 2 at level 14");

  AST_NOT_PRESENT: assert property (@(posedge clock_i) disable iff (rst_i)
    req_i.valid && translate && xlate_entry[15:13] == 3'h0 |-> !wr_en ##1 resp_o.irq && resp_o.irq_code == 4'h3)
    else $error("Absent page not faulted");

  AST_ONE_CYCLE: assert property (@(posedge clock_i) disable iff (rst_i)
    req_i.valid |=> $onehot({resp_o.bus_valid, resp_o.shadow_valid, resp_o.irq}))
    else $error("Reference not answered in one cycle");

  AST_RING3_WINDOW: assert property (@(posedge clock_i) disable iff (rst_i)
    req_i.valid && in_window && paging_on_i && ctrl.ring == 2'h3 |=> resp_o.shadow_valid)
    else $error("Ring 3 did not reach page tables");

  AST_EXT_WINDOW: assert property (@(posedge clock_i) disable iff (rst_i)
    extended_mode_i |-> in_window == (req_i.vaddr[15:9] == 7'h7F))
    else $error("Extended window not the top 512 words");

  AST_NORMAL_WINDOW: assert property (@(posedge clock_i) disable iff (rst_i)
    !extended_mode_i |-> in_window == (req_i.vaddr[15:8] == 8'hFF))
    else $error("Normal window not the top 256 words");

  AST_NORMAL_SHADOW_READ: assert property (@(posedge clock_i) disable iff (rst_i)
    req_i.valid && shadow_hit && !extended_mode_i |=> resp_o.shadow_rdata == $past(shadow_entry[15:0]))
    else $error("Normal window word not a whole entry");

  AST_EXT_PROT_READ: assert property (@(posedge clock_i) disable iff (rst_i)
    req_i.valid && shadow_hit && extended_mode_i && !req_i.vaddr[0] |=> resp_o.shadow_rdata[8:0] == 9'h000)
    else $error("Protection word carries page bits");

  AST_EXT_PPN_READ: assert property (@(posedge clock_i) disable iff (rst_i)
    req_i.valid && shadow_hit && extended_mode_i && req_i.vaddr[0]
      |=> resp_o.shadow_rdata == {2'h0, $past(shadow_entry[29:16])})
    else $error("Page-number word wrong");

  AST_VPN_INDEX: assert property (@(posedge clock_i) disable iff (rst_i)
    xlate_idx[5:0] == req_i.vaddr[15:10])
    else $error("Page index not from address bits 10 to 15");

  AST_PRIMARY_TABLE: assert property (@(posedge clock_i) disable iff (rst_i)
    req_i.pc_rel || !alternate_table_enable_i |-> xlate_idx[7:6] == ctrl.table_sel)
    else $error("Primary table not chosen");

  AST_USED_ON_ACCESS: assert property (@(posedge clock_i) disable iff (rst_i)
    xlate_ok |-> wr_en && wr_mask[11] && wr_data[11])
    else $error("Used flag not set on access");

  AST_NO_WRITTEN_ON_READ: assert property (@(posedge clock_i) disable iff (rst_i)
    xlate_ok && req_i.acc != ACC_WRITE |-> !wr_mask[12])
    else $error("Written flag touched without a write");

  AST_VIOLATION_NO_WRITE: assert property (@(posedge clock_i) disable iff (rst_i)
    req_i.valid && translate && protection_violation |-> !wr_en)
    else $error("Table written on a violation");

  AST_IRQ_LEVEL: assert property (@(posedge clock_i) disable iff (rst_i)
    resp_o.irq |-> resp_o.irq_level == 4'hE)
    else $error("Interrupt not to level 14");

  AST_PAGING_OFF_ADDR: assert property (@(posedge clock_i) disable iff (rst_i)
    req_i.valid && !paging_on_i && !in_window |=> resp_o.bus_valid && resp_o.paddr == {8'h00, $past(req_i.vaddr)})
    else $error("Paging off address not passed through");

  AST_NORMAL_SHADOW_WRITE: assert property (@(posedge clock_i) disable iff (rst_i)
    req_i.valid && shadow_hit && !extended_mode_i && req_i.acc == ACC_WRITE
      |-> wr_en && wr_idx == req_i.vaddr[7:0] && wr_mask == 32'h0000_FFFF)
    else $error("Normal window write not a whole entry");

  AST_EXT_SHADOW_WRITE: assert property (@(posedge clock_i) disable iff (rst_i)
    req_i.valid && shadow_hit && extended_mode_i && req_i.acc == ACC_WRITE
      |-> wr_en && wr_idx == req_i.vaddr[8:1] && wr_mask == (req_i.vaddr[0] ? 32'h3FFF_0000 : 32'h0000_FE00))
    else $error("Extended window write wrong half");

  AST_RING_CHECK: assert property (@(posedge clock_i) disable iff (rst_i)
    req_i.valid && translate && !not_present && ctrl.ring < xlate_entry[10:9] |=> resp_o.irq && resp_o.irq_code == 4'h2)
    else $error("Ring breach not trapped");

  AST_PCR_READ_FORMAT: assert property (@(posedge clock_i) disable iff (rst_i)
    pcr_rdata_o[15:11] == 5'h00 && pcr_rdata_o[2] == 1'b0)
    else $error("Control read-back format wrong");

  AST_SHADOW_NO_BUS: assert property (@(posedge clock_i) disable iff (rst_i)
    req_i.valid && shadow_hit |=> !resp_o.bus_valid && !resp_o.irq)
    else $error("Window access reached memory");
endmodule : pat_translator

// file: test/pat_core_model.sv
// Processor core model issuing one-cycle memory references
`timescale 1ns/1ps
module pat_core_model import pat_pkg::*; (
  // Clock
  input wire logic clock_i,
  // Reference to the translator
  output pat_req_t req_o
);
  // Drive one reference for one cycle, entered at a falling edge
  task automatic send(input logic [15:0] va, input pat_acc_t acc, input logic pc_rel, input logic [15:0] wd);
    req_o.valid = 1'b1;
    req_o.vaddr = va;
    req_o.acc = acc;
    req_o.pc_rel = pc_rel;
    req_o.wdata = wd;
    @(negedge clock_i);
  endtask : send

  // Release; stale address, data and pc_rel lines show the inverse of the last value, acc keeps it
  task automatic idle();
    req_o.valid = 1'b0;
    req_o.vaddr = ~req_o.vaddr;
    req_o.wdata = ~req_o.wdata;
    req_o.pc_rel = ~req_o.pc_rel;
    @(negedge clock_i);
  endtask : idle

  initial begin
    req_o = '0;
  end
endmodule : pat_core_model

// file: test/pat_translator_bench.sv
// Self-checking bench for the paged address translator
`timescale 1ns/1ps
module pat_translator_bench;
  import pat_pkg::*;
  typedef struct packed {
    logic [2:0] kind;
    logic [23:0] val;
    logic [23:0] mask;
  } pat_note_t;
  localparam logic [2:0] K_BUS = 3'h1;
  localparam logic [2:0] K_SH = 3'h2;
  localparam logic [2:0] K_IRQ = 3'h4;
  localparam logic [23:0] M_ALL = 24'hFF_FFFF;
  localparam logic [23:0] E_PROT = {16'h0000, IRQ_LEVEL, CODE_PROT_VIOL};
  localparam logic [23:0] E_FAULT = {16'h0000, IRQ_LEVEL, CODE_PAGE_FAULT};
  logic clock_i;
  logic rst_i;
  logic [3:0] lvl;
  logic ext;
  logic pg_on;
  logic alt_en;
  pat_req_t req;
  pat_resp_t resp;
  logic pcr_wr;
  logic [15:0] pcr_wd;
  logic [3:0] pcr_rl;
  logic [15:0] pcr_rd;
  int num_errors;
  int samples_checked;
  int cycles;
  logic [31:0] lfsr_q;
  pat_note_t notes[$];
  pat_note_t pend;
  logic has_pend;
  logic [2:0] got_k;
  logic [31:0] r;
  logic [8:0] ppn_a;
  logic [8:0] ppn_b;
  logic [13:0] ppn_c;
  logic [9:0] off;
  logic [15:0] e_a;
  logic [15:0] p_c;

  pat_core_model u_pat_core_model (.clock_i(clock_i), .req_o(req));
  pat_translator u_pat_translator (
    .clock_i(clock_i), .rst_i(rst_i), .program_level_i(lvl), .extended_mode_i(ext),
    .paging_on_i(pg_on), .alternate_table_enable_i(alt_en), .req_i(req), .resp_o(resp),
    .pcr_wr_i(pcr_wr), .pcr_wdata_i(pcr_wd), .pcr_rd_level_i(pcr_rl), .pcr_rdata_o(pcr_rd)
  );

  function automatic logic [31:0] rnd();
    lfsr_q = {lfsr_q[30:0], 1'b0} ^ (lfsr_q[31] ? 32'h0040_0007 : 32'h0000_0000);
    return lfsr_q;
  endfunction : rnd

  function automatic logic [15:0] pcr_word(input logic [3:0] lv, input logic [1:0] t, a, rg);
    return {5'h00, t, a, lv, 1'b0, rg};
  endfunction : pcr_word

  task automatic cmp(input logic [23:0] got, input logic [23:0] exp, input logic [23:0] mask);
    samples_checked++;
    if ((got & mask) !== (exp & mask)) begin
      num_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got & mask, exp & mask);
    end
  endtask : cmp

  task automatic cmp_kind(input logic [2:0] got, input logic [2:0] exp);
    cmp({21'h00_0000, got}, {21'h00_0000, exp}, M_ALL);
  endtask : cmp_kind

  task automatic cmp_addr(input logic [23:0] got, input logic [23:0] exp, input logic [23:0] mask);
    cmp(got, exp, mask);
  endtask : cmp_addr

  task automatic cmp_word(input logic [15:0] got, input logic [23:0] exp, input logic [23:0] mask);
    cmp({8'h00, got}, exp, mask);
  endtask : cmp_word

  task automatic cmp_irq(input logic [3:0] lv, input logic [3:0] code, input logic [23:0] exp);
    cmp({16'h0000, lv, code}, exp, M_ALL);
  endtask : cmp_irq

  // Note the expected answer, then issue the reference
  task automatic ref_t(input logic [15:0] va, input pat_acc_t acc, input logic pc, input logic [15:0] wd,
                       input logic [2:0] k, input logic [23:0] v, input logic [23:0] m);
    notes.push_back('{kind: k, val: v, mask: m});
    u_pat_core_model.send(va, acc, pc, wd);
  endtask : ref_t

  task automatic pcr_load(input logic [3:0] lv, input logic [1:0] t, a, rg);
    pcr_wr = 1'b1;
    pcr_wd = pcr_word(lv, t, a, rg);
    @(negedge clock_i);
    pcr_wr = 1'b0;
    pcr_wd = ~pcr_wd;
    @(negedge clock_i);
  endtask : pcr_load

  task automatic final_report();
    $display("checked=%0d errors=%0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : final_report

  initial begin
    clock_i = 1'b0;
    forever #20 clock_i = ~clock_i;
  end

  // Answer monitor: one answer per reference, one cycle later
  always @(posedge clock_i) begin
    if (rst_i) begin
      has_pend = 1'b0;
    end else begin
      got_k = {resp.irq, resp.shadow_valid, resp.bus_valid};
      if (!has_pend) pend = '0;
      if (has_pend || got_k != 3'h0) begin
        cmp_kind(got_k, pend.kind);
        if (pend.kind == K_BUS) cmp_addr(resp.paddr, pend.val, pend.mask);
        if (pend.kind == K_SH) cmp_word(resp.shadow_rdata, pend.val, pend.mask);
        if (pend.kind == K_IRQ) cmp_irq(resp.irq_level, resp.irq_code, pend.val);
      end
      has_pend = (notes.size() != 0);
      if (has_pend) pend = notes.pop_front();
    end
  end

  always @(posedge clock_i) begin
    cycles++;
    if (cycles > 3000) begin
      num_errors++;
      final_report();
    end
  end

  initial begin
    rst_i = 1'b1; lvl = 4'h5; ext = 1'b0; pg_on = 1'b1; alt_en = 1'b0;
    pcr_wr = 1'b0; pcr_wd = 16'h0000; pcr_rl = 4'h0; lfsr_q = 32'hda1f_a8dd;
    num_errors = 0; samples_checked = 0; cycles = 0; has_pend = 1'b0;
    repeat (8) @(negedge clock_i);
    rst_i = 1'b0;
    @(negedge clock_i);
    pcr_load(4'h5, 2'h1, 2'h2, 2'h3);
    pcr_load(4'h6, 2'h1, 2'h1, 2'h0);
    pcr_load(4'h2, 2'h3, 2'h3, 2'h3);
    pcr_rl = 4'h5;
    repeat (2) @(negedge clock_i);
    cmp_word(pcr_rd, {8'h00, pcr_word(4'h5, 2'h1, 2'h2, 2'h3)}, M_ALL);
    $display("test control registers done");
    r = rnd(); ppn_a = r[8:0]; off = r[19:10]; r = rnd(); ppn_b = r[8:0]; ppn_c = r[22:9];
    e_a = {3'h7, 2'h0, 2'h2, ppn_a};
    ref_t(16'hFF43, ACC_WRITE, 1'b1, e_a, K_SH, 24'h00_0000, 24'h00_0000);
    ref_t({6'h03, off}, ACC_READ, 1'b1, 16'h0000, K_BUS, {5'h00, ppn_a, off}, M_ALL);
    ref_t(16'hFF43, ACC_READ, 1'b1, 16'h0000, K_SH, {8'h00, e_a | 16'h0800}, M_ALL);
    ref_t({6'h03, ~off}, ACC_WRITE, 1'b1, r[15:0], K_BUS, {5'h00, ppn_a, ~off}, M_ALL);
    ref_t(16'hFF43, ACC_READ, 1'b1, 16'h0000, K_SH, {8'h00, e_a | 16'h1800}, M_ALL);
    ref_t(16'hFF43, ACC_WRITE, 1'b1, e_a, K_SH, 24'h00_0000, 24'h00_0000);
    ref_t(16'hFF43, ACC_READ, 1'b1, 16'h0000, K_SH, {8'h00, e_a}, M_ALL);
    $display("test translation and flags done");
    ref_t(16'hFF83, ACC_WRITE, 1'b1, {3'h7, 2'h0, 2'h1, ppn_b}, K_SH, 24'h00_0000, 24'h00_0000);
    alt_en = 1'b1;
    ref_t({6'h03, off}, ACC_READ, 1'b0, 16'h0000, K_BUS, {5'h00, ppn_b, off}, M_ALL);
    ref_t({6'h03, off}, ACC_READ, 1'b1, 16'h0000, K_BUS, {5'h00, ppn_a, off}, M_ALL);
    ref_t({6'h03, off}, ACC_INDIRECT, 1'b1, 16'h0000, K_BUS, {5'h00, ppn_a, off}, M_ALL);
    ref_t({6'h03, off}, ACC_READ, 1'b0, 16'h0000, K_BUS, {5'h00, ppn_b, off}, M_ALL);
    alt_en = 1'b0;
    ref_t({6'h03, off}, ACC_READ, 1'b0, 16'h0000, K_BUS, {5'h00, ppn_a, off}, M_ALL);
    $display("test alternate table done");
    ref_t(16'hFF44, ACC_WRITE, 1'b1, {3'h3, 4'h0, ppn_b}, K_SH, 24'h00_0000, 24'h00_0000);
    ref_t(16'hFF45, ACC_WRITE, 1'b1, 16'h0000, K_SH, 24'h00_0000, 24'h00_0000);
    ref_t({6'h04, off}, ACC_WRITE, 1'b1, 16'h0000, K_IRQ, E_PROT, M_ALL);
    ref_t(16'hFF44, ACC_READ, 1'b1, 16'h0000, K_SH, {8'h00, 3'h3, 4'h0, ppn_b}, M_ALL);
    ref_t({6'h05, off}, ACC_FETCH, 1'b1, 16'h0000, K_IRQ, E_FAULT, M_ALL);
    lvl = 4'h6;
    ref_t({6'h03, off}, ACC_READ, 1'b1, 16'h0000, K_IRQ, E_PROT, M_ALL);
    ref_t(16'hFF43, ACC_READ, 1'b1, 16'h0000, K_IRQ, E_FAULT, M_ALL);
    pg_on = 1'b0;
    ref_t(16'hFF43, ACC_READ, 1'b1, 16'h0000, K_SH, {8'h00, e_a | 16'h0800}, M_ALL);
    ref_t(r[31:16] & 16'hFDFF, ACC_READ, 1'b1, 16'h0000, K_BUS, {8'h00, r[31:16] & 16'hFDFF}, M_ALL);
    pg_on = 1'b1;
    $display("test protection and window done");
    ext = 1'b1;
    lvl = 4'h2;
    p_c = {3'h7, 2'h0, 2'h1, 9'h000};
    ref_t(16'hFF8E, ACC_WRITE, 1'b1, p_c, K_SH, 24'h00_0000, 24'h00_0000);
    ref_t(16'hFF8F, ACC_WRITE, 1'b1, {2'h0, ppn_c}, K_SH, 24'h00_0000, 24'h00_0000);
    ref_t({6'h07, off}, ACC_READ, 1'b1, 16'h0000, K_BUS, {ppn_c, off}, M_ALL);
    ref_t(16'hFF8F, ACC_READ, 1'b1, 16'h0000, K_SH, {10'h000, ppn_c}, 24'h00_3FFF);
    ref_t(16'hFF8E, ACC_READ, 1'b1, 16'h0000, K_SH, {8'h00, p_c | 16'h0800}, 24'h00_FE00);
    u_pat_core_model.idle();
    repeat (2) @(negedge clock_i);
    cmp(24'(notes.size()), 24'h00_0000, M_ALL);
    $display("test extended mode done");
    final_report();
  end
endmodule : pat_translator_bench
